/* File: sdas_pkg.sv */
// Shared constants and types for the card access status controller.
`default_nettype none
package sdas_pkg;
  // Timing.
  localparam int unsigned CLK_HZ            = 200_000_000;
  localparam int unsigned TICK_PERIOD_US    = 1000;
  localparam int unsigned TICK_CYC          = (CLK_HZ / 1_000_000) * TICK_PERIOD_US;
  localparam int unsigned SLOW_INTERVAL_MS  = 1000;
  localparam int unsigned FAST_INTERVAL_MS  = 100;
  localparam int unsigned SLOW_TICKS        = SLOW_INTERVAL_MS * 1000 / TICK_PERIOD_US;
  localparam int unsigned FAST_TICKS        = FAST_INTERVAL_MS * 1000 / TICK_PERIOD_US;
  // Register byte offsets.
  localparam logic [3:0]  OFS_STATUS        = 4'h0;
  localparam logic [3:0]  OFS_CONTROL       = 4'h4;
  localparam logic [3:0]  OFS_IRQ_STATUS    = 4'h8;
  localparam logic [3:0]  OFS_IRQ_MASK      = 4'hC;
  // Status register fields.
  localparam int unsigned STS_READY_BIT     = 0;
  localparam int unsigned STS_BUSY_BIT      = 1;
  localparam int unsigned STS_PRESENT_BIT   = 2;
  localparam int unsigned STS_STATE_LSB     = 4;
  // Control register fields.
  localparam int unsigned CTL_HALT_BIT      = 0;
  localparam logic        HALT_RESET        = 1'b0;
  // Interrupt event bits.
  localparam int unsigned IRQ_W             = 5;
  localparam int unsigned IRQ_INSERT_BIT    = 0;
  localparam int unsigned IRQ_REMOVE_BIT    = 1;
  localparam int unsigned IRQ_RFAIL_BIT     = 2;
  localparam int unsigned IRQ_STOPPED_BIT   = 3;
  localparam int unsigned IRQ_REFUSED_BIT   = 4;
  localparam logic [4:0]  IRQ_RESET         = 5'h00;
  // Log destination roots.
  localparam logic [1:0]  LOG_ROOT_NONE     = 2'h0;
  localparam logic [1:0]  LOG_ROOT_PERIODIC = 2'h1;
  localparam logic [1:0]  LOG_ROOT_TRACE    = 2'h2;
  // Fixed volume label; the value is arbitrary.
  localparam logic [63:0] VOLUME_LABEL      = 64'h4341_5244_564F_4C31;
  // Card access states.
  typedef enum logic [2:0] {
    ST_ABSENT,
    ST_RECOG,
    ST_UNUSABLE,
    ST_STANDBY,
    ST_ACCESS,
    ST_STOPPING,
    ST_STOPPED
  } sdas_state_t;
  // Host maintenance operations.
  typedef enum logic [2:0] {
    OP_BROWSE,
    OP_UPLOAD,
    OP_DELETE,
    OP_FORMAT,
    OP_DOWNLOAD,
    OP_MKDIR,
    OP_RENAME
  } sdas_op_t;
endpackage
`default_nettype wire

/* File: sdas_sync.sv */
// Two flip-flop level synchroniser for an asynchronous pin.
`default_nettype none
module sdas_sync (
  // Clock and reset.
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  // Level.
  input  wire logic i_async,
  output logic      o_sync
);
  typedef struct packed {
    logic meta;
    logic sync;
  } sdas_sync_t;

  sdas_sync_t s_reg;
  sdas_sync_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.meta = i_async;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_sync = s_reg.sync;
endmodule
`default_nettype wire

/* File: sdas_blink.sv */
// Flash pattern generator counting millisecond ticks.
`default_nettype none
module sdas_blink #(
  parameter int unsigned HALF_TICKS = 1000
) (
  // Clock and reset.
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  // Control.
  input  wire logic i_tick,
  input  wire logic i_run,
  // Pattern.
  output logic      o_phase
);
  localparam int unsigned CW = $clog2(HALF_TICKS + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_TICKS - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          phase;
  } sdas_blink_t;

  sdas_blink_t b_reg;
  sdas_blink_t b_next;

  // A stopped pattern restarts lit, so every flash begins with a full lit interval.
  always_comb begin
    b_next = b_reg;
    if (!i_run) begin
      b_next.cnt   = '0;
      b_next.phase = 1'b1;
    end else if (i_tick) begin
      if (b_reg.cnt == LAST) begin
        b_next.cnt   = '0;
        b_next.phase = ~b_reg.phase;
      end else begin
        b_next.cnt = b_reg.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      b_reg <= '{cnt: '0, phase: 1'b1};
    end else begin
      b_reg <= b_next;
    end
  end

  assign o_phase = b_reg.phase;
endmodule
`default_nettype wire

/* File: sdas_top.sv */
// Card access state, status lamp, flags, host gating and register slave.
`default_nettype none
module sdas_top #(
  parameter int unsigned P_TICK_CYC = sdas_pkg::TICK_CYC
) (
  // Clock and reset.
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  // Avalon-MM slave.
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Interrupt.
  output logic             o_irq,
  // Card slot and card engine.
  input  wire logic        i_card_detect,
  input  wire logic        i_recog_done,
  input  wire logic        i_recog_ok,
  input  wire logic        i_access_active,
  output logic             o_recog_start,
  output logic             o_access_halt,
  // Status lamp and flags.
  output logic             o_led,
  output logic             o_card_ready_flag,
  output logic             o_card_busy_flag,
  // Host maintenance requests.
  input  wire logic        i_ctrl_running,
  input  wire logic        i_host_req,
  input  wire logic [2:0]  i_host_op,
  output logic             o_host_accept,
  output logic             o_host_refuse,
  output logic             o_format_start,
  output logic             o_format_quick,
  output logic [63:0]      o_volume_label,
  // Log instruction destinations.
  input  wire logic        i_log_req,
  input  wire logic        i_log_is_trace,
  input  wire logic [7:0]  i_log_subdir,
  output logic             o_log_valid,
  output logic [1:0]       o_log_root,
  output logic [7:0]       o_log_subdir
);
  localparam int unsigned PW = $clog2(P_TICK_CYC + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(P_TICK_CYC - 1);
  localparam int unsigned SW = $bits(sdas_pkg::sdas_state_t);

  typedef struct packed {
    sdas_pkg::sdas_state_t st;
    logic                  halt_req;
    logic                  halt_prev;
    logic                  led;
    logic                  ready;
    logic                  busy;
    logic [PW-1:0]         pre;
    logic                  tick;
    logic [4:0]            irq_st;
    logic [4:0]            irq_mask;
    logic                  ack;
    logic [31:0]           rdata;
    logic                  host_acc;
    logic                  host_ref;
    logic                  fmt;
    logic                  recog_start;
    logic                  log_vld;
    logic [1:0]            log_root;
    logic [7:0]            log_sub;
  } sdas_top_t;

  sdas_top_t r_reg;
  sdas_top_t r_next;
  logic      present;
  logic      slow_phase;
  logic      fast_phase;
  logic      halt_rise;
  logic      op_ok;
  logic      wr_en;
  logic [4:0] ev;

  sdas_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_async   (i_card_detect),
    .o_sync    (present)
  );

  // Separate generators keep each pattern phase-clean when the state switches.
  sdas_blink #(
    .HALF_TICKS (sdas_pkg::SLOW_TICKS)
  ) u_slow (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_tick    (r_reg.tick),
    .i_run     (r_reg.st == sdas_pkg::ST_RECOG || r_reg.st == sdas_pkg::ST_STOPPING),
    .o_phase   (slow_phase)
  );

  sdas_blink #(
    .HALF_TICKS (sdas_pkg::FAST_TICKS)
  ) u_fast (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_tick    (r_reg.tick),
    .i_run     (r_reg.st == sdas_pkg::ST_ACCESS),
    .o_phase   (fast_phase)
  );

  assign halt_rise = r_reg.halt_req && !r_reg.halt_prev;
  assign wr_en     = i_avs_write && r_reg.ack;
  assign op_ok     = i_host_op <= 3'(sdas_pkg::OP_FORMAT);

  always_comb begin
    r_next             = r_reg;
    ev                 = '0;
    r_next.halt_prev   = r_reg.halt_req;
    r_next.recog_start = 1'b0;
    r_next.host_acc    = 1'b0;
    r_next.host_ref    = 1'b0;
    r_next.fmt         = 1'b0;
    r_next.log_vld     = 1'b0;
    // Millisecond tick divider.
    r_next.tick = 1'b0;
    if (r_reg.pre == PRE_LAST) begin
      r_next.pre  = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.pre = r_reg.pre + PW'(1);
    end
    // Card state machine; removal wins over everything.
    if (!present) begin
      if (r_reg.st != sdas_pkg::ST_ABSENT) begin
        ev[sdas_pkg::IRQ_REMOVE_BIT] = 1'b1;
      end
      r_next.st = sdas_pkg::ST_ABSENT;
    end else begin
      case (r_reg.st)
        sdas_pkg::ST_ABSENT: begin
          r_next.st          = sdas_pkg::ST_RECOG;
          r_next.recog_start = 1'b1;
          ev[sdas_pkg::IRQ_INSERT_BIT] = 1'b1;
        end
        sdas_pkg::ST_RECOG: begin
          if (halt_rise) begin
            r_next.st = sdas_pkg::ST_STOPPING;
          end else if (i_recog_done) begin
            r_next.st = i_recog_ok ? sdas_pkg::ST_STANDBY : sdas_pkg::ST_UNUSABLE;
            ev[sdas_pkg::IRQ_RFAIL_BIT] = !i_recog_ok;
          end
        end
        sdas_pkg::ST_STANDBY: begin
          if (halt_rise) begin
            r_next.st = sdas_pkg::ST_STOPPING;
          end else if (i_access_active) begin
            r_next.st = sdas_pkg::ST_ACCESS;
          end
        end
        sdas_pkg::ST_ACCESS: begin
          if (halt_rise) begin
            r_next.st = sdas_pkg::ST_STOPPING;
          end else if (!i_access_active) begin
            r_next.st = sdas_pkg::ST_STANDBY;
          end
        end
        sdas_pkg::ST_STOPPING: begin
          if (!i_access_active) begin
            r_next.st = sdas_pkg::ST_STOPPED;
            ev[sdas_pkg::IRQ_STOPPED_BIT] = 1'b1;
          end
        end
        sdas_pkg::ST_STOPPED: begin
          r_next.st = sdas_pkg::ST_STOPPED;
        end
        sdas_pkg::ST_UNUSABLE: begin
          r_next.st = sdas_pkg::ST_UNUSABLE;
        end
        default: begin
          r_next.st = sdas_pkg::ST_ABSENT;
        end
      endcase
    end
    // Lamp pattern follows the current state.
    case (r_reg.st)
      sdas_pkg::ST_STANDBY:  r_next.led = 1'b1;
      sdas_pkg::ST_RECOG:    r_next.led = slow_phase;
      sdas_pkg::ST_STOPPING: r_next.led = slow_phase;
      sdas_pkg::ST_ACCESS:   r_next.led = fast_phase;
      default:               r_next.led = 1'b0;
    endcase
    r_next.ready = present && (r_reg.st == sdas_pkg::ST_STANDBY || r_reg.st == sdas_pkg::ST_ACCESS);
    r_next.busy  = i_access_active && r_reg.st == sdas_pkg::ST_ACCESS;
    // Host maintenance gating; a card that is not ready also refuses.
    if (i_host_req) begin
      if (present && !i_ctrl_running && r_reg.ready && op_ok) begin
        r_next.host_acc = 1'b1;
        r_next.fmt      = i_host_op == 3'(sdas_pkg::OP_FORMAT);
      end else begin
        r_next.host_ref = 1'b1;
        ev[sdas_pkg::IRQ_REFUSED_BIT] = 1'b1;
      end
    end
    // Log destination selection.
    if (i_log_req) begin
      r_next.log_vld  = 1'b1;
      r_next.log_root = i_log_is_trace ? sdas_pkg::LOG_ROOT_TRACE : sdas_pkg::LOG_ROOT_PERIODIC;
      r_next.log_sub  = i_log_subdir;
    end
    // Bus slave: one wait cycle, then the access completes.
    r_next.ack   = (i_avs_read || i_avs_write) && !r_reg.ack;
    r_next.rdata = '0;
    if (i_avs_read && !r_reg.ack) begin
      case (i_avs_address)
        sdas_pkg::OFS_STATUS: begin
          r_next.rdata[sdas_pkg::STS_READY_BIT]   = r_reg.ready;
          r_next.rdata[sdas_pkg::STS_BUSY_BIT]    = r_reg.busy;
          r_next.rdata[sdas_pkg::STS_PRESENT_BIT] = present;
          r_next.rdata[sdas_pkg::STS_STATE_LSB +: SW] = r_reg.st;
        end
        sdas_pkg::OFS_CONTROL:    r_next.rdata[sdas_pkg::CTL_HALT_BIT] = r_reg.halt_req;
        sdas_pkg::OFS_IRQ_STATUS: r_next.rdata[sdas_pkg::IRQ_W-1:0] = r_reg.irq_st;
        sdas_pkg::OFS_IRQ_MASK:   r_next.rdata[sdas_pkg::IRQ_W-1:0] = r_reg.irq_mask;
        default:                  r_next.rdata = '0;
      endcase
    end
    if (wr_en && i_avs_byteenable[0] && i_avs_address == sdas_pkg::OFS_CONTROL) begin
      r_next.halt_req = i_avs_writedata[sdas_pkg::CTL_HALT_BIT];
    end
    if (wr_en && i_avs_byteenable[0] && i_avs_address == sdas_pkg::OFS_IRQ_MASK) begin
      r_next.irq_mask = i_avs_writedata[sdas_pkg::IRQ_W-1:0];
    end
    // Write one to clear; a new event in the same cycle keeps its bit set.
    if (wr_en && i_avs_byteenable[0] && i_avs_address == sdas_pkg::OFS_IRQ_STATUS) begin
      r_next.irq_st = r_reg.irq_st & ~i_avs_writedata[sdas_pkg::IRQ_W-1:0];
    end
    r_next.irq_st = r_next.irq_st | ev;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      r_reg          <= '0;
      r_reg.st       <= sdas_pkg::ST_ABSENT;
      r_reg.halt_req <= sdas_pkg::HALT_RESET;
      r_reg.irq_st   <= sdas_pkg::IRQ_RESET;
      r_reg.irq_mask <= sdas_pkg::IRQ_RESET;
      r_reg.log_root <= sdas_pkg::LOG_ROOT_NONE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_avs_readdata    = r_reg.rdata;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !r_reg.ack;
  assign o_irq             = |(r_reg.irq_st & r_reg.irq_mask);
  assign o_recog_start     = r_reg.recog_start;
  assign o_access_halt     = r_reg.st == sdas_pkg::ST_STOPPING || r_reg.st == sdas_pkg::ST_STOPPED;
  assign o_led             = r_reg.led;
  assign o_card_ready_flag = r_reg.ready;
  assign o_card_busy_flag  = r_reg.busy;
  assign o_host_accept     = r_reg.host_acc;
  assign o_host_refuse     = r_reg.host_ref;
  assign o_format_start    = r_reg.fmt;
  assign o_format_quick    = 1'b1;
  assign o_volume_label    = sdas_pkg::VOLUME_LABEL;
  assign o_log_valid       = r_reg.log_vld;
  assign o_log_root        = r_reg.log_root;
  assign o_log_subdir      = r_reg.log_sub;

  // Checks; the lamp lags the state by one cycle.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  property p_led_standby;
    r_reg.st == sdas_pkg::ST_STANDBY |=> o_led;
  endproperty
  a_led_standby: assert property (p_led_standby) else $error("lamp not steady in standby");

  property p_led_recog;
    r_reg.st == sdas_pkg::ST_RECOG |=> o_led == $past(slow_phase);
  endproperty
  a_led_recog: assert property (p_led_recog) else $error("lamp not slow flashing in recognition");

  property p_led_stop;
    r_reg.st == sdas_pkg::ST_STOPPING |=> o_led == $past(slow_phase);
  endproperty
  a_led_stop: assert property (p_led_stop) else $error("lamp not slow flashing while stopping");

  property p_led_access;
    r_reg.st == sdas_pkg::ST_ACCESS |=> o_led == $past(fast_phase);
  endproperty
  a_led_access: assert property (p_led_access) else $error("lamp not fast flashing in access");

  property p_led_off;
    (r_reg.st == sdas_pkg::ST_ABSENT || r_reg.st == sdas_pkg::ST_UNUSABLE || r_reg.st == sdas_pkg::ST_STOPPED)
      |=> !o_led;
  endproperty
  a_led_off: assert property (p_led_off) else $error("lamp lit in an off state");

  property p_ready;
    o_card_ready_flag |-> $past(r_reg.st == sdas_pkg::ST_STANDBY || r_reg.st == sdas_pkg::ST_ACCESS);
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag without a usable card");

  property p_busy;
    !i_access_active |=> !o_card_busy_flag;
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag held after access ended");

  property p_halt;
    halt_rise && present && (r_reg.st == sdas_pkg::ST_RECOG || r_reg.st == sdas_pkg::ST_STANDBY ||
      r_reg.st == sdas_pkg::ST_ACCESS) |=> r_reg.st == sdas_pkg::ST_STOPPING && o_access_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("halt request did not stop access");

  property p_stopped_hold;
    r_reg.st == sdas_pkg::ST_STOPPED && present |=> r_reg.st == sdas_pkg::ST_STOPPED;
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("halted state left without removal");

  property p_refuse;
    i_host_req && (!present || i_ctrl_running) |=> o_host_refuse && !o_host_accept;
  endproperty
  a_refuse: assert property (p_refuse) else $error("host operation not refused");

  property p_wait;
    (i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus access not answered in time");

  c_recog:  cover property (r_reg.st == sdas_pkg::ST_RECOG ##1 r_reg.st == sdas_pkg::ST_STANDBY);
  c_access: cover property (r_reg.st == sdas_pkg::ST_ACCESS ##1 r_reg.st == sdas_pkg::ST_STANDBY);
  c_stop:   cover property (r_reg.st == sdas_pkg::ST_STOPPING ##1 r_reg.st == sdas_pkg::ST_STOPPED);
  c_format: cover property (o_format_start);
endmodule
`default_nettype wire

/* File: sdas_card_model.sv */
// Behavioural card slot and card engine that sit at the far side of the controller.
`default_nettype none
module sdas_card_model #(
  parameter int P_RECOG_CYC = 10000
) (
  // Clock and reset.
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  // Bench commands.
  input  wire logic i_insert,
  input  wire logic i_good,
  input  wire logic i_access_req,
  // From the controller.
  input  wire logic i_recog_start,
  input  wire logic i_access_halt,
  // To the controller.
  output logic      o_card_detect,
  output logic      o_recog_done,
  output logic      o_recog_ok,
  output logic      o_access_active
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always @(posedge i_clk_sys) begin
    o_card_detect <= i_insert;
    o_recog_done  <= 1'b0;
    // The qualifier shows the wrong answer outside the done pulse.
    o_recog_ok    <= ~i_good;
    if (!i_rstn || !i_insert) begin
      cnt <= 0;
    end else if (i_recog_start) begin
      cnt <= P_RECOG_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        o_recog_done <= 1'b1;
        o_recog_ok   <= i_good;
      end
    end
    // The engine gives up card access once a halt is signalled.
    o_access_active <= i_insert && i_access_req && !i_access_halt;
  end
endmodule
`default_nettype wire

/* File: sdas_tb.sv */
// Self-checking bench for the card access status controller.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys = 1'b0, i_rstn = 1'b0;
  logic [3:0]  i_avs_address = 4'h0, i_avs_byteenable = 4'hF;
  logic        i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic        i_ctrl_running = 1'b0, i_host_req = 1'b0;
  logic [2:0]  i_host_op = 3'h0;
  logic        i_log_req = 1'b0, i_log_is_trace = 1'b0;
  logic [7:0]  i_log_subdir = 8'h00, sd;
  logic        ins = 1'b0, good = 1'b1, acc = 1'b0;
  wire logic   i_card_detect, i_recog_done, i_recog_ok, i_access_active;
  wire logic   o_avs_waitrequest, o_irq, o_recog_start, o_access_halt, o_led;
  wire logic   o_card_ready_flag, o_card_busy_flag, o_host_accept, o_host_refuse;
  wire logic   o_format_start, o_format_quick, o_log_valid;
  wire logic [31:0] o_avs_readdata;
  wire logic [63:0] o_volume_label;
  wire logic [1:0]  o_log_root;
  wire logic [7:0]  o_log_subdir;
  int          err_total = 0, cmp_count = 0, g, i, rs_n = 0;
  int          seed = 32'h00cebdc0;
  string       nm_q[$];
  logic [63:0] v_q[$];
  always #2.5 i_clk_sys = ~i_clk_sys;
  sdas_top #(.P_TICK_CYC(4)) uut (
    .i_clk_sys, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_irq, .i_card_detect,
    .i_recog_done, .i_recog_ok, .i_access_active, .o_recog_start, .o_access_halt, .o_led,
    .o_card_ready_flag, .o_card_busy_flag, .i_ctrl_running, .i_host_req, .i_host_op,
    .o_host_accept, .o_host_refuse, .o_format_start, .o_format_quick, .o_volume_label,
    .i_log_req, .i_log_is_trace, .i_log_subdir, .o_log_valid, .o_log_root, .o_log_subdir);
  sdas_card_model #(.P_RECOG_CYC(10000)) card (
    .i_clk_sys, .i_rstn, .i_insert(ins), .i_good(good), .i_access_req(acc),
    .i_recog_start(o_recog_start), .i_access_halt(o_access_halt), .o_card_detect(i_card_detect),
    .o_recog_done(i_recog_done), .o_recog_ok(i_recog_ok), .o_access_active(i_access_active));
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      err_total++;
      $display("unexpected %s: expected %0h, seen %0h", nm, expv, seen);
    end
  endtask
  task automatic expv(input string nm, input logic [63:0] v);
    nm_q.push_back(nm);
    v_q.push_back(v);
  endtask
  task automatic pop(input logic [63:0] seen);
    if (v_q.size() == 0) begin
      err_total++;
      $display("unexpected result %0h with nothing pending", seen);
    end else begin
      chk(nm_q.pop_front(), seen, v_q.pop_front());
    end
  endtask
  // Results are matched in arrival order, so answers must come back in the order their requests were issued.
  always @(posedge i_clk_sys) begin
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) pop({32'h0, o_avs_readdata});
    if (o_host_accept === 1'b1 || o_host_refuse === 1'b1) begin
      pop({60'h0, o_format_start, o_format_quick, o_host_accept, o_host_refuse});
    end
    if (o_log_valid === 1'b1) pop({54'h0, o_log_root, o_log_subdir});
    if (o_recog_start === 1'b1) rs_n++;
  end
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_avs_address   <= a;
    i_avs_write     <= wr;
    i_avs_read      <= !wr;
    i_avs_writedata <= d;
    // The request stands until waitrequest is seen low at a rising edge.
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 100);
    chk("bus answer", n < 100, 1'b1);
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] v);
    expv("readdata", {32'h0, v});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic host(input logic [2:0] op, input logic [3:0] v);
    @(posedge i_clk_sys);
    i_host_req <= 1'b1;
    i_host_op  <= op;
    expv("host answer", {60'h0, v});
    @(posedge i_clk_sys);
    i_host_req <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic led_gap(output int gap);
    logic l;
    gap = 0;
    @(negedge i_clk_sys);
    // The first interval depends on where the tick divider stands, so the gap is taken between two toggles.
    for (int c = 0; c < 2; c++) begin
      l = o_led;
      for (int k = 0; k < 20000 && o_led === l; k++) @(negedge i_clk_sys);
    end
    l = o_led;
    while (gap < 20000 && o_led === l) begin
      @(negedge i_clk_sys);
      gap++;
    end
  endtask
  task automatic final_report;
    chk("pending results", nm_q.size(), 0);
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    rd(sdas_pkg::OFS_STATUS, 32'h0);
    rd(4'h2, 32'h0);
    rd(sdas_pkg::OFS_CONTROL, 32'h0);
    host(3'h0, 4'h5);
    wt(1);
    chk("lamp", o_led, 1'b0);
    $display("test empty slot done");
    @(posedge i_clk_sys);
    ins <= 1'b1;
    led_gap(g);
    chk("slow gap", g, 4000);
    for (i = 0; i < 20000 && o_card_ready_flag !== 1'b1; i++) @(negedge i_clk_sys);
    chk("ready", o_card_ready_flag, 1'b1);
    wt(2);
    chk("lamp", o_led, 1'b1);
    bus(1'b1, sdas_pkg::OFS_STATUS, 32'hFFFFFFFF);
    rd(sdas_pkg::OFS_STATUS, 32'h35);
    $display("test recognition done");
    // Permitted operations are accepted, the unsupported ones refused.
    for (i = 0; i < 7; i++) host(3'(i), i == 3 ? 4'hE : (i < 4 ? 4'h6 : 4'h5));
    chk("label", o_volume_label, sdas_pkg::VOLUME_LABEL);
    @(posedge i_clk_sys);
    i_ctrl_running <= 1'b1;
    host(3'h1, 4'h5);
    i_ctrl_running <= 1'b0;
    for (i = 0; i < 4; i++) begin
      sd = 8'($random(seed));
      @(posedge i_clk_sys);
      i_log_req      <= 1'b1;
      i_log_is_trace <= i[0];
      i_log_subdir   <= sd;
      expv("log", {54'h0, i[0] ? sdas_pkg::LOG_ROOT_TRACE : sdas_pkg::LOG_ROOT_PERIODIC, sd});
      @(posedge i_clk_sys);
      i_log_req <= 1'b0;
    end
    $display("test host and log done");
    @(posedge i_clk_sys);
    acc <= 1'b1;
    led_gap(g);
    chk("fast gap", g, 400);
    chk("busy", o_card_busy_flag, 1'b1);
    rd(sdas_pkg::OFS_STATUS, 32'h47);
    @(posedge i_clk_sys);
    acc <= 1'b0;
    wt(10);
    chk("busy", o_card_busy_flag, 1'b0);
    chk("lamp", o_led, 1'b1);
    rd(sdas_pkg::OFS_IRQ_STATUS, 32'h11);
    bus(1'b1, sdas_pkg::OFS_IRQ_MASK, 32'h1);
    wt(2);
    chk("irq", o_irq, 1'b1);
    bus(1'b1, sdas_pkg::OFS_IRQ_STATUS, 32'h1);
    wt(2);
    chk("irq", o_irq, 1'b0);
    rd(sdas_pkg::OFS_IRQ_STATUS, 32'h10);
    // A write without its low byte enabled must leave the halt request alone.
    i_avs_byteenable <= 4'hE;
    bus(1'b1, sdas_pkg::OFS_CONTROL, 32'h1);
    i_avs_byteenable <= 4'hF;
    rd(sdas_pkg::OFS_CONTROL, 32'h0);
    $display("test access and interrupt done");
    @(posedge i_clk_sys);
    acc <= 1'b1;
    wt(20);
    bus(1'b1, sdas_pkg::OFS_CONTROL, 32'h1);
    wt(20);
    chk("halt", o_access_halt, 1'b1);
    chk("lamp", o_led, 1'b0);
    chk("busy", o_card_busy_flag, 1'b0);
    bus(1'b1, sdas_pkg::OFS_CONTROL, 32'h0);
    bus(1'b1, sdas_pkg::OFS_CONTROL, 32'h1);
    rd(sdas_pkg::OFS_CONTROL, 32'h1);
    wt(1);
    chk("halt", o_access_halt, 1'b1);
    rd(sdas_pkg::OFS_IRQ_STATUS, 32'h18);
    @(posedge i_clk_sys);
    ins <= 1'b0;
    acc <= 1'b0;
    wt(10);
    chk("halt", o_access_halt, 1'b0);
    rd(sdas_pkg::OFS_STATUS, 32'h0);
    bus(1'b1, sdas_pkg::OFS_CONTROL, 32'h0);
    @(posedge i_clk_sys);
    good <= 1'b0;
    ins  <= 1'b1;
    wt(10100);
    rd(sdas_pkg::OFS_STATUS, 32'h24);
    wt(1);
    chk("lamp", o_led, 1'b0);
    chk("ready", o_card_ready_flag, 1'b0);
    chk("recog starts", rs_n, 2);
    $display("test halt and reinsertion done");
    final_report();
  end
endmodule
`default_nettype wire
